// ===== pkg/wrsu_pkg.sv
/*
 * Shared constants and carrier types for the working register stack unit.
 * Assumes a 16-bit data path, byte addressed data space, one core clock.
 */
package wrsu_pkg;
   localparam int unsigned WRSU_DW = 16;
   localparam int unsigned WRSU_NREG = 16;
   localparam logic [15:0] WRSU_FILE_ACCUMULATOR_ALIAS_BASE = 16'h0000;
   localparam logic [15:0] WRSU_FILE_ACCUMULATOR_ALIAS_END = 16'h0020;
   localparam logic [15:0] WRSU_WORKING_REG_TWO_OFS = 16'h0004;
   localparam logic [3:0] WRSU_SP_IDX = 4'hf;
   localparam logic [15:0] WRSU_SP_RESET = 16'h0800;
   localparam logic [15:0] WRSU_STACK_FLOOR = 16'h0800;
   localparam logic [15:0] WRSU_WORD_STEP = 16'h0002;
   localparam logic [15:0] WRSU_ZERO16 = 16'h0000;
   localparam logic [7:0] WRSU_ZERO8 = 8'h00;
   localparam int unsigned WRSU_NSHADOW = 4;
   // Status flag mask: N(3), OV(2), Z(1), C(0) in the low byte, DC(8).
   localparam logic [15:0] WRSU_SHADOW_FLAG_MASK = 16'h010f;
   localparam int unsigned WRSU_PC_LO_W = 16;

   typedef enum logic [2:0] {
      WRSU_OP_NONE = 3'h0,
      WRSU_OP_PUSH = 3'h1,
      WRSU_OP_POP = 3'h2,
      WRSU_OP_CALL = 3'h3,
      WRSU_OP_EXC = 3'h4,
      WRSU_OP_RET = 3'h5,
      WRSU_OP_RETFIE = 3'h6
   } wrsu_stack_op_t;

   typedef enum logic [1:0] {
      WRSU_ST_IDLE = 2'b00,
      WRSU_ST_HIGH = 2'b01,
      WRSU_ST_LOW = 2'b11
   } wrsu_seq_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic byte_en;
      logic [15:0] addr;
      logic [15:0] wdata;
   } wrsu_mem_req_t;

   typedef struct packed {
      logic [15:0] start_addr;
      logic [15:0] end_addr;
      logic [15:0] count;
   } wrsu_loop_ctx_t;
endpackage

// ===== core/wrsu_word_lane.sv
/*
 * One working register with byte lanes and its uninitialized flag.
 * Assumes the parent resolves priority between write sources.
 */
`timescale 1ns/1ns
`default_nettype none
module wrsu_word_lane #(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter bit ALIGN = 1'b0
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic word_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] q_o,
   output logic uninit_o
);
   logic [15:0] val_q;
   logic uninit_q;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         val_q <= RESET_VAL;
      end else begin
         if (wr_lo_i) begin
            val_q[7:0] <= wdata_i[7:0];
         end
         if (wr_hi_i) begin
            val_q[15:8] <= wdata_i[15:8];
         end
         if (ALIGN) begin
            val_q[0] <= 1'b0;
         end
      end
   end

   // The pointer register never starts uninitialized: it has a valid value.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         uninit_q <= !ALIGN;
      end else if (word_i && wr_lo_i && wr_hi_i) begin
         uninit_q <= 1'b0;
      end
   end

   assign q_o = val_q;
   assign uninit_o = uninit_q;
endmodule
`default_nettype wire

// ===== core/wrsu_shadow.sv
/*
 * One-level shadow store for a packed context word.
 * Assumes save and restore are single-cycle pulses from the core.
 */
`timescale 1ns/1ns
`default_nettype none
module wrsu_shadow #(
   parameter int unsigned W = 16
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic save_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] store_q;

   // A single level: each save overwrites the last.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         store_q <= '0;
      end else if (save_i) begin
         store_q <= d_i;
      end
   end

   assign q_o = store_q;
endmodule
`default_nettype wire

// ===== core/wrsu_top.sv
/*
 * Working register array, shadow stores and software stack sequencer.
 * Assumes the core execution and data memory logic run on clk_i and hold
 * each request for one cycle; the data memory answers reads combinationally.
 */
`timescale 1ns/1ns
`default_nettype none
module wrsu_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire wrsu_pkg::wrsu_mem_req_t mem_req_i,
   output logic [15:0] mem_rdata_o,
   output logic mem_hit_o,
   input wire logic ptr_use_i,
   input wire logic [3:0] ptr_idx_i,
   input wire logic ptr_upd_i,
   input wire logic [15:0] ptr_new_i,
   input wire logic reg_wr_i,
   input wire logic reg_byte_i,
   input wire logic [3:0] reg_idx_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [3:0] rd_idx_i,
   output logic [15:0] rd_data_o,
   input wire logic ctx_save_i,
   input wire logic ctx_restore_i,
   input wire logic [15:0] status_i,
   output logic status_load_o,
   output logic [15:0] status_o,
   input wire logic loop_start_i,
   input wire wrsu_pkg::wrsu_loop_ctx_t loop_ctx_i,
   output wrsu_pkg::wrsu_loop_ctx_t loop_shadow_o,
   input wire wrsu_pkg::wrsu_stack_op_t stack_op_i,
   input wire logic [15:0] stack_data_i,
   input wire logic [22:0] pc_i,
   output logic stack_busy_o,
   output wrsu_pkg::wrsu_mem_req_t stack_mem_o,
   input wire logic [15:0] stack_rdata_i,
   output logic [15:0] pop_data_o,
   output logic pop_valid_o,
   output logic stack_err_o,
   output logic dev_reset_req_o
);
   // ****************************************************************
   // Register array and address decode
   // ****************************************************************
   logic [15:0] regs [wrsu_pkg::WRSU_NREG];
   logic [wrsu_pkg::WRSU_NREG-1:0] uninit;
   logic [wrsu_pkg::WRSU_NREG-1:0] wr_lo;
   logic [wrsu_pkg::WRSU_NREG-1:0] wr_hi;
   logic [wrsu_pkg::WRSU_NREG-1:0] wr_word;
   logic [15:0] wdata [wrsu_pkg::WRSU_NREG];
   logic mem_in_range;
   logic [3:0] mem_idx;
   logic [15:0] sp;
   logic sp_wr;
   logic [15:0] sp_next;
   logic rest_wr;
   logic [15:0] shadow_q [wrsu_pkg::WRSU_NSHADOW];
   logic [15:0] flag_shadow;

   assign mem_in_range = mem_req_i.valid && (mem_req_i.addr >= wrsu_pkg::WRSU_FILE_ACCUMULATOR_ALIAS_BASE)
      && (mem_req_i.addr < wrsu_pkg::WRSU_FILE_ACCUMULATOR_ALIAS_END);
   assign mem_idx = mem_req_i.addr[4:1];
   assign mem_hit_o = mem_in_range;
   assign sp = regs[wrsu_pkg::WRSU_SP_IDX];
   assign rest_wr = ctx_restore_i;

   // Read path: a byte read on an odd address returns the high byte in the
   // low lane so the core sees it as a plain byte.
   always_comb begin
      mem_rdata_o = wrsu_pkg::WRSU_ZERO16;
      if (mem_in_range && !mem_req_i.write) begin
         if (mem_req_i.byte_en && mem_req_i.addr[0]) begin
            mem_rdata_o = {wrsu_pkg::WRSU_ZERO8, regs[mem_idx][15:8]};
         end else if (mem_req_i.byte_en) begin
            mem_rdata_o = {wrsu_pkg::WRSU_ZERO8, regs[mem_idx][7:0]};
         end else begin
            mem_rdata_o = regs[mem_idx];
         end
      end
   end

   assign rd_data_o = regs[rd_idx_i];

   // ****************************************************************
   // Write arbitration
   // ****************************************************************
   // Priority, lowest first: pointer update, stack pointer step, direct
   // register write, shadow restore, mapped memory write. The memory write
   // is last so that a pointer aimed at its own address keeps the data.
   always_comb begin
      for (int i = 0; i < wrsu_pkg::WRSU_NREG; i++) begin
         wr_lo[i] = 1'b0;
         wr_hi[i] = 1'b0;
         wr_word[i] = 1'b0;
         wdata[i] = regs[i];
         if (ptr_upd_i && ptr_idx_i == 4'(i)) begin
            wr_lo[i] = 1'b1;
            wr_hi[i] = 1'b1;
            wdata[i] = ptr_new_i;
         end
         if (sp_wr && i == int'(wrsu_pkg::WRSU_SP_IDX)) begin
            wr_lo[i] = 1'b1;
            wr_hi[i] = 1'b1;
            wdata[i] = sp_next;
         end
         if (reg_wr_i && reg_idx_i == 4'(i)) begin
            wr_lo[i] = 1'b1;
            wr_hi[i] = !reg_byte_i;
            wr_word[i] = !reg_byte_i;
            wdata[i] = reg_wdata_i;
         end
         if (rest_wr && i < int'(wrsu_pkg::WRSU_NSHADOW)) begin
            wr_lo[i] = 1'b1;
            wr_hi[i] = 1'b1;
            wr_word[i] = 1'b1;
            wdata[i] = shadow_q[i];
         end
         if (mem_in_range && mem_req_i.write && mem_idx == 4'(i)) begin
            if (mem_req_i.byte_en) begin
               wr_lo[i] = !mem_req_i.addr[0];
               wr_hi[i] = mem_req_i.addr[0];
               wr_word[i] = 1'b0;
               wdata[i] = {mem_req_i.wdata[7:0], mem_req_i.wdata[7:0]};
            end else begin
               wr_lo[i] = 1'b1;
               wr_hi[i] = 1'b1;
               wr_word[i] = 1'b1;
               wdata[i] = mem_req_i.wdata;
            end
         end
      end
   end

   for (genvar g = 0; g < wrsu_pkg::WRSU_NREG; g++) begin : g_lane
      wrsu_word_lane #(
         .RESET_VAL((g == int'(wrsu_pkg::WRSU_SP_IDX)) ? wrsu_pkg::WRSU_SP_RESET : wrsu_pkg::WRSU_ZERO16),
         .ALIGN(g == int'(wrsu_pkg::WRSU_SP_IDX))
      ) u_lane (
         .clk_i(clk_i),
         .reset_n_i(reset_n_i),
         .wr_lo_i(wr_lo[g]),
         .wr_hi_i(wr_hi[g]),
         .word_i(wr_word[g]),
         .wdata_i(wdata[g]),
         .q_o(regs[g]),
         .uninit_o(uninit[g])
      );
   end

   // ****************************************************************
   // Shadow stores
   // ****************************************************************
   // The shadows have no port of their own; only the save pulses load them.
   for (genvar s = 0; s < wrsu_pkg::WRSU_NSHADOW; s++) begin : g_shadow
      wrsu_shadow #(
         .W(wrsu_pkg::WRSU_DW)
      ) u_shadow (
         .clk_i(clk_i),
         .reset_n_i(reset_n_i),
         .save_i(ctx_save_i),
         .d_i(regs[s]),
         .q_o(shadow_q[s])
      );
   end

   wrsu_shadow #(
      .W(wrsu_pkg::WRSU_DW)
   ) u_flag_shadow (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .save_i(ctx_save_i),
      .d_i(status_i & wrsu_pkg::WRSU_SHADOW_FLAG_MASK),
      .q_o(flag_shadow)
   );

   // Only the five flags change on restore; other status bits pass through.
   assign status_load_o = ctx_restore_i;
   assign status_o = (status_i & ~wrsu_pkg::WRSU_SHADOW_FLAG_MASK) | flag_shadow;

   wrsu_shadow #(
      .W($bits(wrsu_pkg::wrsu_loop_ctx_t))
   ) u_loop_shadow (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .save_i(loop_start_i),
      .d_i(loop_ctx_i),
      .q_o(loop_shadow_o)
   );

   // ****************************************************************
   // Software stack sequencer
   // ****************************************************************
   wrsu_pkg::wrsu_seq_t seq_q;
   wrsu_pkg::wrsu_stack_op_t op_q;
   logic [15:0] hi_word_q;
   logic [15:0] pc_lo;
   logic [15:0] hi_word;
   logic start;

   assign pc_lo = pc_i[wrsu_pkg::WRSU_PC_LO_W-1:0];
   assign start = (seq_q == wrsu_pkg::WRSU_ST_IDLE) && (stack_op_i != wrsu_pkg::WRSU_OP_NONE);

   always_comb begin
      hi_word = {wrsu_pkg::WRSU_ZERO8, 1'b0, pc_i[22:16]};
      if (stack_op_i == wrsu_pkg::WRSU_OP_EXC) begin
         hi_word = {status_i[7:0], 1'b0, pc_i[22:16]};
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seq_q <= wrsu_pkg::WRSU_ST_IDLE;
         op_q <= wrsu_pkg::WRSU_OP_NONE;
         hi_word_q <= wrsu_pkg::WRSU_ZERO16;
      end else begin
         unique case (seq_q)
            wrsu_pkg::WRSU_ST_IDLE: begin
               if (start && (stack_op_i == wrsu_pkg::WRSU_OP_CALL
                     || stack_op_i == wrsu_pkg::WRSU_OP_EXC)) begin
                  seq_q <= wrsu_pkg::WRSU_ST_HIGH;
                  op_q <= stack_op_i;
                  hi_word_q <= hi_word;
               end else if (start && (stack_op_i == wrsu_pkg::WRSU_OP_RET
                     || stack_op_i == wrsu_pkg::WRSU_OP_RETFIE)) begin
                  seq_q <= wrsu_pkg::WRSU_ST_LOW;
                  op_q <= stack_op_i;
               end
            end
            wrsu_pkg::WRSU_ST_HIGH: begin
               seq_q <= wrsu_pkg::WRSU_ST_IDLE;
               op_q <= wrsu_pkg::WRSU_OP_NONE;
            end
            wrsu_pkg::WRSU_ST_LOW: begin
               seq_q <= wrsu_pkg::WRSU_ST_IDLE;
               op_q <= wrsu_pkg::WRSU_OP_NONE;
            end
            default: begin
               seq_q <= wrsu_pkg::WRSU_ST_IDLE;
            end
         endcase
      end
   end

   assign stack_busy_o = (seq_q != wrsu_pkg::WRSU_ST_IDLE);

   // Every stack cycle writes at the pointer then steps up, or steps down
   // then reads: the pointer always names the first free word.
   always_comb begin
      stack_mem_o = '0;
      sp_wr = 1'b0;
      sp_next = sp;
      if (start && (stack_op_i == wrsu_pkg::WRSU_OP_PUSH || stack_op_i == wrsu_pkg::WRSU_OP_CALL
            || stack_op_i == wrsu_pkg::WRSU_OP_EXC)) begin
         stack_mem_o.valid = 1'b1;
         stack_mem_o.write = 1'b1;
         stack_mem_o.addr = sp;
         stack_mem_o.wdata = (stack_op_i == wrsu_pkg::WRSU_OP_PUSH) ? stack_data_i : pc_lo;
         sp_wr = 1'b1;
         sp_next = sp + wrsu_pkg::WRSU_WORD_STEP;
      end else if (seq_q == wrsu_pkg::WRSU_ST_HIGH) begin
         stack_mem_o.valid = 1'b1;
         stack_mem_o.write = 1'b1;
         stack_mem_o.addr = sp;
         stack_mem_o.wdata = hi_word_q;
         sp_wr = 1'b1;
         sp_next = sp + wrsu_pkg::WRSU_WORD_STEP;
      end else if ((start && stack_op_i != wrsu_pkg::WRSU_OP_NONE)
            || seq_q == wrsu_pkg::WRSU_ST_LOW) begin
         stack_mem_o.valid = 1'b1;
         stack_mem_o.addr = sp - wrsu_pkg::WRSU_WORD_STEP;
         sp_wr = 1'b1;
         sp_next = sp - wrsu_pkg::WRSU_WORD_STEP;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pop_data_o <= wrsu_pkg::WRSU_ZERO16;
         pop_valid_o <= 1'b0;
      end else begin
         pop_valid_o <= stack_mem_o.valid && !stack_mem_o.write;
         if (stack_mem_o.valid && !stack_mem_o.write) begin
            pop_data_o <= stack_rdata_i;
         end
      end
   end

   // ****************************************************************
   // Error and reset requests
   // ****************************************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stack_err_o <= 1'b0;
         dev_reset_req_o <= 1'b0;
      end else begin
         stack_err_o <= stack_mem_o.valid && (stack_mem_o.addr < wrsu_pkg::WRSU_STACK_FLOOR);
         dev_reset_req_o <= ptr_use_i && uninit[ptr_idx_i];
      end
   end
endmodule
`default_nettype wire

// ===== tb/wrsu_chk.sv
/* Concurrent checks on the ports of the working register stack unit.
   Assumes it is bound into wrsu_top and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none
module wrsu_chk (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire wrsu_pkg::wrsu_mem_req_t mem_req_i,
   input wire logic mem_hit_o,
   input wire logic ptr_use_i,
   input wire logic [3:0] rd_idx_i,
   input wire logic [15:0] rd_data_o,
   input wire logic ctx_restore_i,
   input wire logic [15:0] status_i,
   input wire logic status_load_o,
   input wire logic [15:0] status_o,
   input wire wrsu_pkg::wrsu_stack_op_t stack_op_i,
   input wire logic [15:0] stack_data_i,
   input wire logic stack_busy_o,
   input wire wrsu_pkg::wrsu_mem_req_t stack_mem_o,
   input wire logic pop_valid_o,
   input wire logic stack_err_o,
   input wire logic dev_reset_req_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic below_w = stack_mem_o.valid && stack_mem_o.addr < wrsu_pkg::WRSU_STACK_FLOOR;
   sequence call_taken;
      stack_op_i == wrsu_pkg::WRSU_OP_CALL && !stack_busy_o;
   endsequence
   sequence exc_taken;
      stack_op_i == wrsu_pkg::WRSU_OP_EXC && !stack_busy_o;
   endsequence
   chk_window_hit: assert property (mem_req_i.valid |-> mem_hit_o == (mem_req_i.addr < 16'h0020))
      else $error("register window decode wrong");
   chk_sp_align: assert property (rd_idx_i == 4'hf |-> !rd_data_o[0])
      else $error("stack pointer odd");
   chk_restore_load: assert property (status_load_o == ctx_restore_i)
      else $error("status load not tied to restore");
   chk_restore_keep: assert property (ctx_restore_i |->
      (status_o & ~wrsu_pkg::WRSU_SHADOW_FLAG_MASK) == (status_i & ~wrsu_pkg::WRSU_SHADOW_FLAG_MASK))
      else $error("restore touched unsaved status bits");
   chk_call_upper: assert property (call_taken |=> stack_busy_o && stack_mem_o.write && stack_mem_o.wdata[15:8] == 8'h00)
      else $error("call upper byte not zero");
   chk_exc_status: assert property (exc_taken |=> stack_mem_o.wdata[15:8] == $past(status_i[7:0]))
      else $error("exception did not stack status byte");
   chk_push_move: assert property (stack_op_i == wrsu_pkg::WRSU_OP_PUSH && !stack_busy_o |->
      stack_mem_o.valid && stack_mem_o.write && stack_mem_o.wdata == stack_data_i)
      else $error("push did not write its data");
   chk_pop_answer: assert property (stack_mem_o.valid && !stack_mem_o.write |=> pop_valid_o)
      else $error("stack read gave no pop data");
   chk_bad_ptr: assert property (dev_reset_req_o |-> $past(ptr_use_i))
      else $error("reset request without pointer use");
   chk_floor_err: assert property (stack_err_o |-> $past(below_w))
      else $error("stack error without low address");
endmodule
bind wrsu_top wrsu_chk wrsu_chk_i (.clk_i, .reset_n_i, .mem_req_i, .mem_hit_o, .ptr_use_i, .rd_idx_i,
   .rd_data_o, .ctx_restore_i, .status_i, .status_load_o, .status_o, .stack_op_i, .stack_data_i,
   .stack_busy_o, .stack_mem_o, .pop_valid_o, .stack_err_o, .dev_reset_req_o);
`default_nettype wire

// ===== tb/wrsu_mem_model.sv
/* Data memory seen by the stack port of the working register stack unit.
   Assumes one-cycle requests; reads are answered in the same cycle. */
`timescale 1ns/1ns
`default_nettype none
module wrsu_mem_model (
   input wire logic clk_i,
   input wire wrsu_pkg::wrsu_mem_req_t req_i,
   output logic [15:0] rdata_o
);
   // A plain array keeps the model portable; only address bits 8:1 index it, so it covers a 256-word window.
   logic [15:0] mem [256];
   logic [255:0] held_q = '0;
   logic [15:0] last_q = 16'h0000;
   logic [7:0] slot;
   assign slot = req_i.addr[8:1];
   // Outside a read of a written word the bus shows the inverse of its own value in the cycle before, so it flips every such cycle.
   always @* begin
      if (req_i.valid && !req_i.write && held_q[slot])
         rdata_o = mem[slot];
      else
         rdata_o = ~last_q;
   end
   always @(posedge clk_i) begin
      if (req_i.valid && req_i.write) begin
         mem[slot] <= req_i.wdata;
         held_q[slot] <= 1'b1;
      end
      last_q <= rdata_o;
   end
endmodule
`default_nettype wire

// ===== tb/wrsu_top_test.sv
/* Self-checking bench for the working register stack unit.
   Assumes the stack port is served by wrsu_mem_model. */
`timescale 1ns/1ns
`default_nettype none
module wrsu_top_test;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   wrsu_pkg::wrsu_mem_req_t mem_req_i = '0, stack_mem_o;
   logic [15:0] ptr_new_i = '0, reg_wdata_i = '0, status_i = '0, stack_data_i = '0;
   logic [15:0] mem_rdata_o, rd_data_o, status_o, stack_rdata_i, pop_data_o;
   logic ptr_use_i = 0, ptr_upd_i = 0, reg_wr_i = 0, reg_byte_i = 0, ctx_save_i = 0, ctx_restore_i = 0;
   logic loop_start_i = 0, mem_hit_o, status_load_o, stack_busy_o, pop_valid_o, stack_err_o, dev_reset_req_o;
   logic [3:0] ptr_idx_i = '0, reg_idx_i = '0, rd_idx_i = '0;
   wrsu_pkg::wrsu_loop_ctx_t loop_ctx_i = '0, loop_shadow_o, lc;
   wrsu_pkg::wrsu_stack_op_t stack_op_i = wrsu_pkg::WRSU_OP_NONE;
   logic [22:0] pc_i = '0, pc;
   logic [15:0] d, a, b, st, sh [4];
   int unsigned r;
   int n_fail = 0;
   int n_tests = 0;
   wrsu_top wrsu_top_i (.clk_i, .reset_n_i, .mem_req_i, .mem_rdata_o, .mem_hit_o, .ptr_use_i, .ptr_idx_i,
      .ptr_upd_i, .ptr_new_i, .reg_wr_i, .reg_byte_i, .reg_idx_i, .reg_wdata_i, .rd_idx_i, .rd_data_o,
      .ctx_save_i, .ctx_restore_i, .status_i, .status_load_o, .status_o, .loop_start_i, .loop_ctx_i,
      .loop_shadow_o, .stack_op_i, .stack_data_i, .pc_i, .stack_busy_o, .stack_mem_o, .stack_rdata_i,
      .pop_data_o, .pop_valid_o, .stack_err_o, .dev_reset_req_o);
   wrsu_mem_model wrsu_mem_model_i (.clk_i, .req_i(stack_mem_o), .rdata_o(stack_rdata_i));
   always #25 clk_i = ~clk_i;
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask
   task automatic rel;
      mem_req_i.valid = 1'b0;
      ptr_use_i = 1'b0;
      ptr_upd_i = 1'b0;
      reg_wr_i = 1'b0;
      ctx_save_i = 1'b0;
      ctx_restore_i = 1'b0;
      loop_start_i = 1'b0;
      stack_op_i = wrsu_pkg::WRSU_OP_NONE;
      tick;
   endtask
   task automatic chk(input string what, input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ck_reg(input logic [3:0] i, input logic [15:0] exp);
      rd_idx_i = i;
      #1;
      chk("register", rd_data_o, exp);
   endtask
   task automatic wr(input logic [3:0] i, input logic [15:0] v, input logic bt);
      reg_wr_i = 1'b1;
      reg_byte_i = bt;
      reg_idx_i = i;
      reg_wdata_i = v;
      tick;
      rel;
   endtask
   task automatic mw(input logic [15:0] ad, input logic [15:0] v, input logic bt);
      mem_req_i = '{1'b1, 1'b1, bt, ad, v};
      tick;
      rel;
   endtask
   task automatic mr(input logic [15:0] ad, input logic bt, input logic [16:0] exp);
      mem_req_i = '{1'b1, 1'b0, bt, ad, 16'h0000};
      #1;
      chk("window read", {mem_hit_o, mem_rdata_o}, exp);
      rel;
   endtask
   task automatic pu(input logic [3:0] i, input logic exp);
      ptr_use_i = 1'b1;
      ptr_idx_i = i;
      tick;
      chk("pointer reset", dev_reset_req_o, exp);
      rel;
   endtask
   function automatic logic [15:0] hiw(input bit exc, input logic [22:0] p, input logic [15:0] s);
      return {exc ? s[7:0] : 8'h00, 1'b0, p[22:16]};
   endfunction
   function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] saved);
      return (cur & ~wrsu_pkg::WRSU_SHADOW_FLAG_MASK) | (saved & wrsu_pkg::WRSU_SHADOW_FLAG_MASK);
   endfunction
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #(5000 * 50);
      n_fail++;
      end_of_test;
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      r = $urandom(32'h3395bf7e);
      repeat (2) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      for (int i = 0; i < 16; i++) ck_reg(i[3:0], i == 15 ? 16'h0800 : 16'h0000);
      pu(4'h3, 1'b1);
      wr(4'h3, 16'h00a5, 1'b1);
      pu(4'h3, 1'b1);
      d = 16'($urandom);
      mw(16'h0006, d, 1'b0);
      pu(4'h3, 1'b0);
      ck_reg(4'h3, d);
      wr(4'h3, 16'h335a, 1'b1);
      ck_reg(4'h3, {d[15:8], 8'h5a});
      mw(wrsu_pkg::WRSU_WORKING_REG_TWO_OFS, d, 1'b0);
      mw(16'h0005, 16'h00c3, 1'b1);
      ck_reg(4'h2, {8'hc3, d[7:0]});
      mr(16'h0005, 1'b1, {1'b1, 16'h00c3});
      mr(16'h0004, 1'b1, {1'b1, 8'h00, d[7:0]});
      mr(16'h0020, 1'b0, 17'h00000);
      mw(16'h0004, 16'h0004, 1'b0);
      d = 16'($urandom);
      ptr_upd_i = 1'b1;
      ptr_idx_i = 4'h2;
      ptr_new_i = 16'h0006;
      mem_req_i = '{1'b1, 1'b1, 1'b0, 16'h0004, d};
      tick;
      rel;
      ck_reg(4'h2, d);
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) begin
            sh[i] = 16'($urandom);
            wr(i[3:0], sh[i], 1'b0);
         end
         st = 16'($urandom);
         status_i = st;
         ctx_save_i = 1'b1;
         tick;
         rel;
      end
      for (int i = 0; i < 4; i++) wr(i[3:0], ~sh[i], 1'b0);
      status_i = ~st;
      ctx_restore_i = 1'b1;
      #1;
      chk("restored status", status_o, merge(~st, st));
      tick;
      rel;
      for (int i = 0; i < 4; i++) ck_reg(i[3:0], sh[i]);
      for (int k = 0; k < 2; k++) begin
         lc = {16'($urandom), 16'($urandom), 16'($urandom)};
         loop_ctx_i = lc;
         loop_start_i = 1'b1;
         tick;
         rel;
         chk("loop shadow", loop_shadow_o, lc);
      end
      mw(16'h001e, 16'h0901, 1'b0);
      ck_reg(4'hf, 16'h0900);
      mw(16'h001e, 16'h0800, 1'b0);
      a = 16'($urandom);
      b = 16'($urandom);
      stack_op_i = wrsu_pkg::WRSU_OP_PUSH;
      stack_data_i = a;
      tick;
      stack_data_i = b;
      tick;
      chk("stack error", stack_err_o, 1'b0);
      rel;
      ck_reg(4'hf, 16'h0804);
      foreach (sh[k]) if (k < 2) begin
         stack_op_i = wrsu_pkg::WRSU_OP_POP;
         tick;
         chk("pop data", {pop_valid_o, pop_data_o}, {1'b1, k ? a : b});
         rel;
      end
      ck_reg(4'hf, 16'h0800);
      for (int k = 0; k < 2; k++) begin
         pc = 23'($urandom);
         pc_i = pc;
         status_i = 16'($urandom);
         stack_op_i = k ? wrsu_pkg::WRSU_OP_EXC : wrsu_pkg::WRSU_OP_CALL;
         tick;
         chk("entry busy", stack_busy_o, 1'b1);
         rel;
         ck_reg(4'hf, 16'h0804);
         stack_op_i = k ? wrsu_pkg::WRSU_OP_RETFIE : wrsu_pkg::WRSU_OP_RET;
         tick;
         chk("upper word", {pop_valid_o, pop_data_o}, {1'b1, hiw(k, pc, status_i)});
         rel;
         chk("lower word", {pop_valid_o, pop_data_o}, {1'b1, pc[15:0]});
         ck_reg(4'hf, 16'h0800);
      end
      mw(16'h001e, 16'h07fe, 1'b0);
      stack_op_i = wrsu_pkg::WRSU_OP_PUSH;
      tick;
      chk("stack error", stack_err_o, 1'b1);
      rel;
      end_of_test;
   end
endmodule
`default_nettype wire
